/* File: logic/irq_flags_pkg.sv */
// Package for the interrupt request flag block: register map, field positions,
// reset values and edge-select encodings.
// Assumes a plain address/strobe register port with read data one cycle later.
package irq_flags_pkg;

   // ********************************************************************
   // Register offsets
   // ********************************************************************
   localparam int          ADDR_W              = 4;
   localparam logic [3:0]  OFS_PIN_TIMER_FLAGS = 4'h0;
   localparam logic [3:0]  OFS_PERIPH_FLAGS    = 4'h1;
   localparam logic [3:0]  OFS_PIN_TIMER_EN    = 4'h2;
   localparam logic [3:0]  OFS_PERIPH_EN       = 4'h3;
   localparam logic [3:0]  OFS_EDGE_SELECT     = 4'h4;
   localparam logic [3:0]  OFS_CONTROL         = 4'h5;

   // ********************************************************************
   // Field positions, first flag register
   // ********************************************************************
   localparam int BIT_INTERVAL_TIMER = 7;
   localparam int BIT_ALWAYS_ONE     = 5;
   localparam int BIT_EVENT_PIN      = 2;
   localparam int BIT_EXT_PIN1       = 1;
   localparam int BIT_EXT_PIN0       = 0;

   // ********************************************************************
   // Field positions, second flag register
   // ********************************************************************
   localparam int BIT_DIRECT_TRANS   = 7;
   localparam int BIT_CONV_END       = 6;
   localparam int BIT_COMPARE_HIGH   = 3;
   localparam int BIT_COMPARE_LOW    = 2;
   localparam int BIT_EVENT_COUNTER  = 0;

   // ********************************************************************
   // Control register fields
   // ********************************************************************
   localparam int BIT_EVENT_PIN_EDGE   = 0;
   localparam int BIT_EVENT_PIN_MODE   = 1;
   localparam int BIT_EXT_PIN0_MODE    = 2;
   localparam int BIT_EXT_PIN1_MODE    = 3;

   // ********************************************************************
   // Masks and reset values
   // ********************************************************************
   localparam logic [7:0] PIN_TIMER_MASK   = 8'h87;
   localparam logic [7:0] PERIPH_MASK      = 8'hcd;
   localparam logic [7:0] PIN_TIMER_ONES   = 8'h20;
   localparam logic [7:0] EDGE_SEL_ONES    = 8'he0;
   localparam logic [7:0] FLAGS_RESET      = 8'h00;
   localparam logic [7:0] ENABLE_RESET     = 8'h00;
   localparam logic [1:0] EDGE_SEL_RESET   = 2'h0;
   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [7:0] COUNTER_MAX      = 8'hff;

   typedef enum logic {
      EDGE_FALLING = 1'b0,
      EDGE_RISING  = 1'b1
   } edge_sel_t;

endpackage

/* File: logic/pin_edge_detect.sv */
// Synchronises one asynchronous pin and flags the selected edge.
// Assumes the pin is asynchronous to sys_clk; output is a one-cycle pulse.
`timescale 1ns/1ps
module pin_edge_detect
   import irq_flags_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic pinIn,
   input  wire logic risingSel,
   output logic      edgePulse
);

   logic stage1_q;
   logic stage2_q;
   logic stage3_q;

   // Pin passes three flops; a change counts once the second and third differ.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_q <= 1'b1;
         stage2_q <= 1'b1;
         stage3_q <= 1'b1;
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   wire logic riseSeen = stage2_q & ~stage3_q;
   wire logic fallSeen = ~stage2_q & stage3_q;

   assign edgePulse = risingSel ? riseSeen : fallSeen;

endmodule

/* File: logic/wrap_detect.sv */
// Detects an 8-bit counter stepping from its maximum value to zero.
// Assumes the counter value arrives from logic on the same clock.
`timescale 1ns/1ps
module wrap_detect
   import irq_flags_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] countIn,
   output logic            wrapPulse
);

   logic [7:0] prev_q;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 8'h00;
      end else begin
         prev_q <= countIn;
      end
   end

   assign wrapPulse = (prev_q == COUNTER_MAX) && (countIn == 8'h00);

endmodule

/* File: logic/interrupt_request_flags.sv */
// Two 8-bit interrupt request flag registers with enables and edge selects.
// Assumes event strobes from peripherals are one-cycle pulses on sys_clk and
// request pins are asynchronous.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Summary of operation
// - Set interval timer flag, bit 7, when its counter wraps FF to 00.
// - Accepting an interrupt never clears a flag.
// - Writing 0 clears a flag; writing 1 leaves it unchanged.
// - Set bit 2 on the selected event pin edge when in interrupt mode.
// - Set bit 1 or 0 on the selected external pin edge in interrupt mode.
// - Bit 5 of the first register always reads 1, ignores writes.
// - Set bit 7 of second register on sleep direct transition with enable.
// - Set bit 6 when conversion ends and start/busy falls to 0.
// - Set bit 3 on high compare match (8-bit) or combined match (16-bit).
// - Set bit 2 on low compare match in 8-bit mode.
// - Set bit 0 on high overflow (16-bit) or either overflow (8-bit).
// - Edge select 0 means falling, 1 rising; both reset to 0.
// - A flag requests an interrupt only while its enable bit is 1.
module interrupt_request_flags
   import irq_flags_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [7:0]        regWdata,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [7:0]        regRdata,
   input  wire logic [7:0]        intervalCount,
   input  wire logic              event_edge_pin,
   input  wire logic              ext_request_pin1,
   input  wire logic              ext_request_pin0,
   input  wire logic              sleepDirectTransition,
   input  wire logic              direct_transition_enable,
   input  wire logic              conversion_start_busy,
   input  wire logic              timer16Mode,
   input  wire logic [7:0]        compare_counter_high,
   input  wire logic [7:0]        compare_value_high,
   input  wire logic [7:0]        compare_counter_low,
   input  wire logic [7:0]        compare_value_low,
   input  wire logic              counter16Mode,
   input  wire logic              eventHighOverflow,
   input  wire logic              eventLowOverflow,
   output logic      [7:0]        pinTimerRequest,
   output logic      [7:0]        periphRequest
);

   // ********************************************************************
   // Registers
   // ********************************************************************
   logic [7:0] pinTimerFlags_q;
   logic [7:0] pinTimerFlags_d;
   logic [7:0] periphFlags_q;
   logic [7:0] periphFlags_d;
   logic [7:0] pinTimerEn_q;
   logic [7:0] periphEn_q;
   logic [1:0] edgeSel_q;
   logic [7:0] control_q;
   logic       busyPrev_q;
   logic       matchHighPrev_q;
   logic       matchLowPrev_q;
   logic [7:0] rdata_q;

   // ********************************************************************
   // Event sources
   // ********************************************************************
   logic intervalWrap;
   logic eventPinEdge;
   logic ext1Edge;
   logic ext0Edge;

   wrap_detect u_wrap (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .countIn   (intervalCount),
      .wrapPulse (intervalWrap)
   );

   pin_edge_detect u_event_pin (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .pinIn     (event_edge_pin),
      .risingSel (control_q[BIT_EVENT_PIN_EDGE]),
      .edgePulse (eventPinEdge)
   );

   pin_edge_detect u_ext_pin1 (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .pinIn     (ext_request_pin1),
      .risingSel (edgeSel_q[1]),
      .edgePulse (ext1Edge)
   );

   pin_edge_detect u_ext_pin0 (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .pinIn     (ext_request_pin0),
      .risingSel (edgeSel_q[0]),
      .edgePulse (ext0Edge)
   );

   // Compare matches are taken on their first cycle so a held match sets once.
   wire logic matchHigh16 = timer16Mode &&
                            ({compare_counter_high, compare_counter_low} ==
                             {compare_value_high, compare_value_low});
   wire logic matchHigh8  = !timer16Mode && (compare_counter_high == compare_value_high);
   wire logic matchHigh   = matchHigh16 | matchHigh8;
   wire logic matchLow    = !timer16Mode && (compare_counter_low == compare_value_low);

   wire logic setIntervalTimer = intervalWrap;
   wire logic setEventPin  = eventPinEdge & control_q[BIT_EVENT_PIN_MODE];
   wire logic setExtPin1   = ext1Edge & control_q[BIT_EXT_PIN1_MODE];
   wire logic setExtPin0   = ext0Edge & control_q[BIT_EXT_PIN0_MODE];
   wire logic setDirect    = sleepDirectTransition & direct_transition_enable;
   wire logic setConvEnd   = busyPrev_q & ~conversion_start_busy;
   wire logic setCmpHigh   = matchHigh & ~matchHighPrev_q;
   wire logic setCmpLow    = matchLow & ~matchLowPrev_q;
   wire logic setEventCnt  = counter16Mode ? eventHighOverflow
                                           : (eventHighOverflow | eventLowOverflow);

   wire logic [7:0] pinTimerSet = 8'({setIntervalTimer, 4'h0, setEventPin, setExtPin1, setExtPin0});
   wire logic [7:0] periphSet   = 8'({setDirect, setConvEnd, 2'h0, setCmpHigh, setCmpLow,
                                      1'b0, setEventCnt});

   // ********************************************************************
   // Register decode
   // ********************************************************************
   wire logic wrPinTimerFlags = regWrite && (regAddr == OFS_PIN_TIMER_FLAGS);
   wire logic wrPeriphFlags   = regWrite && (regAddr == OFS_PERIPH_FLAGS);
   wire logic wrPinTimerEn    = regWrite && (regAddr == OFS_PIN_TIMER_EN);
   wire logic wrPeriphEn      = regWrite && (regAddr == OFS_PERIPH_EN);
   wire logic wrEdgeSel       = regWrite && (regAddr == OFS_EDGE_SELECT);
   wire logic wrControl       = regWrite && (regAddr == OFS_CONTROL);

   // Writing 0 clears, writing 1 keeps; reserved bits always stay 0.
   function automatic logic [7:0] nextFlags(input logic [7:0] cur, input logic [7:0] set,
                                            input logic wr, input logic [7:0] wdata,
                                            input logic [7:0] mask);
      logic [7:0] kept;
      kept = wr ? (cur & wdata) : cur;
      return (kept | set) & mask;
   endfunction

   // No acceptance input exists, so only a write can clear a flag.
   assign pinTimerFlags_d = nextFlags(pinTimerFlags_q, pinTimerSet, wrPinTimerFlags,
                                      regWdata, PIN_TIMER_MASK);
   assign periphFlags_d   = nextFlags(periphFlags_q, periphSet, wrPeriphFlags,
                                      regWdata, PERIPH_MASK);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pinTimerFlags_q <= FLAGS_RESET;
         periphFlags_q   <= FLAGS_RESET;
      end else begin
         pinTimerFlags_q <= pinTimerFlags_d;
         periphFlags_q   <= periphFlags_d;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pinTimerEn_q <= ENABLE_RESET;
         periphEn_q   <= ENABLE_RESET;
         edgeSel_q    <= EDGE_SEL_RESET;
         control_q    <= CONTROL_RESET;
      end else begin
         if (wrPinTimerEn) begin
            pinTimerEn_q <= regWdata;
         end
         if (wrPeriphEn) begin
            periphEn_q <= regWdata;
         end
         if (wrEdgeSel) begin
            edgeSel_q <= regWdata[1:0];
         end
         if (wrControl) begin
            control_q <= regWdata & 8'h0f;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busyPrev_q      <= 1'b0;
         matchHighPrev_q <= 1'b0;
         matchLowPrev_q  <= 1'b0;
      end else begin
         busyPrev_q      <= conversion_start_busy;
         matchHighPrev_q <= matchHigh;
         matchLowPrev_q  <= matchLow;
      end
   end

   // ********************************************************************
   // Read path
   // ********************************************************************
   // Bit 5 of the first flag register is a constant one.
   wire logic [7:0] pinTimerView = pinTimerFlags_q | PIN_TIMER_ONES;

   logic [7:0] rdMux;
   always_comb begin
      unique case (regAddr)
         OFS_PIN_TIMER_FLAGS: rdMux = pinTimerView;
         OFS_PERIPH_FLAGS:    rdMux = periphFlags_q;
         OFS_PIN_TIMER_EN:    rdMux = pinTimerEn_q;
         OFS_PERIPH_EN:       rdMux = periphEn_q;
         OFS_EDGE_SELECT:     rdMux = EDGE_SEL_ONES | {6'h00, edgeSel_q};
         OFS_CONTROL:         rdMux = control_q;
         default:             rdMux = 8'h00;
      endcase
   end

   // Reads have no side effect on the flags; data stand only in the next cycle.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= regRead ? rdMux : 8'h00;
      end
   end

   assign regRdata = rdata_q;

   // ********************************************************************
   // Request outputs
   // ********************************************************************
   assign pinTimerRequest = pinTimerFlags_q & pinTimerEn_q & PIN_TIMER_MASK;
   assign periphRequest   = periphFlags_q & periphEn_q & PERIPH_MASK;

endmodule

/* File: dv/irq_flags_chk.sv */
// Checker for the request flag block: register read data and request outputs.
// Assumes it is bound to interrupt_request_flags and sees only its ports.
`timescale 1ns/1ps
module irq_flags_chk
   import irq_flags_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              reset_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0]        regWdata,
   input wire logic              regWrite,
   input wire logic              regRead,
   input wire logic [7:0]        regRdata,
   input wire logic [7:0]        intervalCount,
   input wire logic              sleepDirectTransition,
   input wire logic              direct_transition_enable,
   input wire logic              conversion_start_busy,
   input wire logic [7:0]        pinTimerRequest,
   input wire logic [7:0]        periphRequest
);
   logic [7:0] enable1_q;
   logic [7:0] enable2_q;

   // Shadow of the enable registers, so that set events can be tied to the requests.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enable1_q <= 8'h00;
         enable2_q <= 8'h00;
      end else if (regWrite) begin
         if (regAddr == OFS_PIN_TIMER_EN) enable1_q <= regWdata;
         if (regAddr == OFS_PERIPH_EN) enable2_q <= regWdata;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_read_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data not zero outside a read");
   a_always_one: assert property ($past(regRead) && $past(regAddr) == OFS_PIN_TIMER_FLAGS
      |-> regRdata[5] && (regRdata & 8'h58) == 8'h00)
      else $error("fixed bits of first flag register wrong");
   a_timer_wrap: assert property ($past(intervalCount) == COUNTER_MAX && intervalCount == 8'h00
      && enable1_q[7] |-> ##[1:2] pinTimerRequest[7])
      else $error("counter wrap did not raise request");
   a_sleep_set: assert property (sleepDirectTransition && direct_transition_enable && enable2_q[7]
      |=> periphRequest[7])
      else $error("direct transition did not raise request");
   a_sleep_gated: assert property (sleepDirectTransition && !direct_transition_enable && !regWrite
      && !periphRequest[7] |=> !periphRequest[7])
      else $error("direct transition raised request while disabled");
   a_conv_end: assert property ($fell(conversion_start_busy) && enable2_q[6]
      |-> ##[1:2] periphRequest[6])
      else $error("conversion end did not raise request");
   a_hold_first: assert property (|($past(pinTimerRequest) & ~pinTimerRequest) |-> $past(regWrite)
      && ($past(regAddr) == OFS_PIN_TIMER_FLAGS || $past(regAddr) == OFS_PIN_TIMER_EN))
      else $error("first request dropped without a write");
   a_hold_second: assert property (|($past(periphRequest) & ~periphRequest) |-> $past(regWrite)
      && ($past(regAddr) == OFS_PERIPH_FLAGS || $past(regAddr) == OFS_PERIPH_EN))
      else $error("second request dropped without a write");
endmodule

bind interrupt_request_flags irq_flags_chk i_chk (.sys_clk, .reset_n, .regAddr, .regWdata, .regWrite,
   .regRead, .regRdata, .intervalCount, .sleepDirectTransition, .direct_transition_enable,
   .conversion_start_busy, .pinTimerRequest, .periphRequest);

/* File: dv/event_source_model.sv */
// Model of the peripherals and pins that raise requests into the flag block.
// Assumes one sys_clk; every task changes its outputs just after a rising edge.
`timescale 1ns/1ps
module event_source_model (
   input  wire logic  sys_clk,
   output logic [7:0] intervalCount,
   output logic [2:0] pins,
   output logic       sleepDt,
   output logic       dtEnable,
   output logic       convBusy,
   output logic       t16,
   output logic       c16,
   output logic [7:0] cntHigh,
   output logic [7:0] cntLow,
   output logic [7:0] valHigh,
   output logic [7:0] valLow,
   output logic       ovfHigh,
   output logic       ovfLow
);
   // Pins idle high, as with a pull-up; compare values never equal the idle counts.
   initial begin
      {intervalCount, cntHigh, cntLow, valHigh, valLow} = 40'h00000_05aa5;
      pins = 3'h7;
      {sleepDt, dtEnable, convBusy, t16, c16, ovfHigh, ovfLow} = 7'h00;
   end

   task automatic timer_wrap();
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         intervalCount <= 8'hfe + 8'(i);
      end
      @(posedge sys_clk);
      intervalCount <= 8'h01;
   endtask

   // Compare values must stay non-zero in both bytes, since idle counts are zero.
   task automatic set_values(input logic [15:0] v);
      @(posedge sys_clk);
      {valHigh, valLow} <= v;
   endtask

   task automatic set_mode(input logic [2:0] m);
      @(posedge sys_clk);
      {dtEnable, t16, c16} <= m;
   endtask

   task automatic strobe(input logic [2:0] sel);
      @(posedge sys_clk);
      {sleepDt, ovfHigh, ovfLow} <= sel;
      @(posedge sys_clk);
      {sleepDt, ovfHigh, ovfLow} <= 3'h0;
   endtask

   task automatic conv_done();
      @(posedge sys_clk);
      convBusy <= 1'b1;
      repeat (3) @(posedge sys_clk);
      convBusy <= 1'b0;
   endtask

   task automatic match(input logic [1:0] sel);
      @(posedge sys_clk);
      {cntHigh, cntLow} <= {sel[1] ? valHigh : 8'h00, sel[0] ? valLow : 8'h00};
      @(posedge sys_clk);
      {cntHigh, cntLow} <= 16'h0000;
   endtask

   // The pins pass a synchroniser, so the level is held long enough to be seen.
   task automatic pin_level(input logic [2:0] v);
      @(posedge sys_clk);
      pins <= v;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

/* File: dv/interrupt_request_flags_tb.sv */
// Testbench for the request flag block, with the event source model beside it.
// Assumes the register map and field positions of irq_flags_pkg.
`timescale 1ns/1ps
module interrupt_request_flags_tb;
   import irq_flags_pkg::*;
   logic              sys_clk = 1'b0;
   logic              reset_n;
   logic [ADDR_W-1:0] regAddr;
   logic [7:0]        regWdata, regRdata, pinTimerRequest, periphRequest;
   logic              regWrite, regRead;
   logic [7:0]        intervalCount, cntHigh, cntLow, valHigh, valLow;
   logic [2:0]        pins;
   logic              sleepDt, dtEnable, convBusy, t16, c16, ovfHigh, ovfLow;
   int                n_mismatch = 0;
   int                check_count = 0;
   int                cycles = 0;

   always #50 sys_clk = ~sys_clk;

   event_source_model i_src (.sys_clk, .intervalCount, .pins, .sleepDt, .dtEnable, .convBusy, .t16,
      .c16, .cntHigh, .cntLow, .valHigh, .valLow, .ovfHigh, .ovfLow);

   interrupt_request_flags i_dut (.sys_clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead,
      .regRdata, .intervalCount, .event_edge_pin(pins[2]), .ext_request_pin1(pins[1]),
      .ext_request_pin0(pins[0]), .sleepDirectTransition(sleepDt), .direct_transition_enable(dtEnable),
      .conversion_start_busy(convBusy), .timer16Mode(t16), .compare_counter_high(cntHigh),
      .compare_value_high(valHigh), .compare_counter_low(cntLow), .compare_value_low(valLow),
      .counter16Mode(c16), .eventHighOverflow(ovfHigh), .eventLowOverflow(ovfLow), .pinTimerRequest,
      .periphRequest);

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {regWrite, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      {regRead, regAddr} <= {1'b1, a};
      @(posedge sys_clk);
      regRead <= 1'b0;
      @(negedge sys_clk);
      chk(regRdata, exp);
   endtask

   task automatic t_reset();
      rd(OFS_PIN_TIMER_FLAGS, 8'h20);
      rd(OFS_PERIPH_FLAGS, 8'h00);
      rd(OFS_EDGE_SELECT, 8'he0);
      rd(4'hf, 8'h00);
      wr(OFS_PIN_TIMER_FLAGS, 8'h87);
      wr(OFS_PERIPH_FLAGS, 8'hcd);
      rd(OFS_PIN_TIMER_FLAGS, 8'h20);
      rd(OFS_PERIPH_FLAGS, 8'h00);
      $display("test reset_values done");
   endtask

   task automatic t_timer();
      wr(OFS_PIN_TIMER_EN, 8'h87);
      i_src.timer_wrap();
      rd(OFS_PIN_TIMER_FLAGS, 8'ha0);
      chk(pinTimerRequest, 8'h80);
      wr(OFS_PIN_TIMER_EN, 8'h00);
      rd(OFS_PIN_TIMER_FLAGS, 8'ha0);
      chk(pinTimerRequest, 8'h00);
      wr(OFS_PIN_TIMER_FLAGS, 8'h07);
      rd(OFS_PIN_TIMER_FLAGS, 8'h20);
      $display("test timer_wrap done");
   endtask

   task automatic t_pins();
      wr(OFS_CONTROL, 8'h0e);
      wr(OFS_PIN_TIMER_EN, 8'h07);
      i_src.pin_level(3'h0);
      rd(OFS_PIN_TIMER_FLAGS, 8'h27);
      chk(pinTimerRequest, 8'h07);
      wr(OFS_PIN_TIMER_FLAGS, 8'h00);
      wr(OFS_EDGE_SELECT, 8'h03);
      i_src.pin_level(3'h7);
      rd(OFS_PIN_TIMER_FLAGS, 8'h23);
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_PIN_TIMER_FLAGS, 8'h00);
      i_src.pin_level(3'h0);
      rd(OFS_PIN_TIMER_FLAGS, 8'h20);
      wr(OFS_CONTROL, 8'h03);
      i_src.pin_level(3'h7);
      rd(OFS_PIN_TIMER_FLAGS, 8'h24);
      $display("test pin_edges done");
   endtask

   task automatic t_periph();
      wr(OFS_PERIPH_EN, 8'hcd);
      i_src.strobe(3'h4);
      rd(OFS_PERIPH_FLAGS, 8'h00);
      i_src.set_mode(3'h4);
      i_src.strobe(3'h4);
      i_src.conv_done();
      i_src.match(2'h3);
      i_src.strobe(3'h1);
      rd(OFS_PERIPH_FLAGS, 8'hcd);
      chk(periphRequest, 8'hcd);
      wr(OFS_PERIPH_FLAGS, 8'h00);
      i_src.set_mode(3'h3);
      i_src.set_values(16'h3cc3);
      i_src.match(2'h1);
      i_src.match(2'h2);
      i_src.strobe(3'h1);
      rd(OFS_PERIPH_FLAGS, 8'h00);
      i_src.match(2'h3);
      i_src.strobe(3'h2);
      rd(OFS_PERIPH_FLAGS, 8'h09);
      wr(OFS_PERIPH_FLAGS, 8'h00);
      i_src.set_mode(3'h0);
      i_src.strobe(3'h2);
      rd(OFS_PERIPH_FLAGS, 8'h01);
      $display("test peripheral_events done");
   endtask

   task automatic t_collision();
      i_src.set_mode(3'h4);
      fork
         i_src.strobe(3'h4);
         wr(OFS_PERIPH_FLAGS, 8'h00);
      join
      rd(OFS_PERIPH_FLAGS, 8'h80);
      $display("test set_beats_clear done");
   endtask

   initial begin
      {regWrite, regRead, regAddr, regWdata} = '0;
      reset_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_timer();
      t_pins();
      t_periph();
      t_collision();
      final_report();
   end
endmodule
